/* common/stlsb_pkg.sv */
// Package of constants for the self-test log sector builder
package stlsb_pkg;
    // Sector geometry
    localparam int unsigned SECTOR_BYTES    = 512;            // Bytes in one log sector
    localparam logic [8:0]  POS_REVISION    = 9'h000;         // Revision byte position
    localparam logic [8:0]  POS_INDEX_LO    = 9'h002;         // Index low byte position
    localparam logic [8:0]  POS_INDEX_HI    = 9'h003;         // Index high byte position
    localparam logic [8:0]  POS_DESC_FIRST  = 9'h004;         // First descriptor byte
    localparam logic [8:0]  POS_DESC_LAST   = 9'h1f1;         // Last descriptor byte (497)
    localparam logic [8:0]  POS_CHECKSUM    = 9'h1ff;         // Checksum byte (511)
    localparam logic [7:0]  LOG_REVISION    = 8'h01;          // Log format revision value
    // Descriptor geometry
    localparam logic [4:0]  DESC_LAST_OFF   = 5'h19;          // Last offset within a descriptor (25)
    localparam logic [4:0]  DESC_USED_BYTES = 5'h0b;          // Offsets 0..10 carry data
    localparam logic [4:0]  ENT_PER_SECTOR  = 5'h12;          // Descriptors per sector (18)
    // Supported log size, at most 65,535 sectors
    localparam logic [15:0] LOG_SECTORS     = 16'h0004;       // Sectors this device implements
    localparam int unsigned SLOT_W          = 7;              // Width of a descriptor slot number
    localparam logic [6:0]  SLOT_COUNT      = 7'h48;          // Total descriptor slots (4 * 18)
    localparam logic [6:0]  SLOT_ONE        = 7'h01;          // Slot step
    localparam int unsigned OFF_W           = 4;              // Stored bytes per slot, as address bits
    localparam int unsigned MEM_AW          = SLOT_W + OFF_W; // Descriptor memory address width
    localparam logic [3:0]  WR_LAST_BYTE    = 4'ha;           // Last stored descriptor byte (10)
    // Descriptor byte offsets
    localparam logic [3:0]  D_LBA_LOW       = 4'h0;           // Captured LBA low register
    localparam logic [3:0]  D_STATUS        = 4'h1;           // Execution status
    localparam logic [3:0]  D_HOURS_LO      = 4'h2;           // Lifetime hours, low byte
    localparam logic [3:0]  D_HOURS_HI      = 4'h3;           // Lifetime hours, high byte
    localparam logic [3:0]  D_CHECKPOINT    = 4'h4;           // Failure checkpoint
    localparam logic [3:0]  D_FAIL_LBA0     = 4'h5;           // Failing address, first byte
    localparam logic [47:0] LBA28_MASK      = 48'h0000_0fff_ffff; // Mask for a 28-bit entry
    // Read side states
    typedef enum logic [1:0] {
        STLSB_IDLE   = 2'b00,  // Waiting for a sector request
        STLSB_STREAM = 2'b01,  // Stepping through byte positions
        STLSB_DRAIN  = 2'b10   // Emitting the final piped byte
    } stlsb_rd_state_t;
endpackage : stlsb_pkg

/* rtl/stlsb_builder.sv */
// Self-test log sector builder: records descriptors and streams log sectors
`timescale 1ns/1ps
module stlsb_builder (
    input  wire logic        clk,            // System clock, 100 MHz
    input  wire logic        rst,            // Synchronous reset, active high
    input  wire logic        test_start,     // Pulse: self-test subcommand issued
    input  wire logic [7:0]  test_lba_low,   // LBA low register at issue
    input  wire logic        test_done,      // Pulse: self-test completed
    input  wire logic [7:0]  test_status,    // Execution status at completion
    input  wire logic [15:0] test_hours,     // Power-on lifetime hours
    input  wire logic [7:0]  test_checkpoint,// Failure checkpoint
    input  wire logic [47:0] test_fail_lba,  // First failing address
    input  wire logic        test_is_28bit,  // Entry comes from a 28-bit test
    input  wire logic        rd_req,         // Pulse: read one log sector
    input  wire logic [15:0] rd_sector,      // Sector number to read
    output logic             rec_busy,       // Descriptor being stored
    output logic             rd_busy,        // Sector stream in progress
    output logic             log_valid,      // Byte strobe
    output logic [7:0]       log_data,       // Sector byte
    output logic             log_last,       // Marks byte 511
    output logic [15:0]      log_index       // Newest descriptor index
);
    import stlsb_pkg::*;

    // Function: a position lies in the descriptor area
    function automatic logic in_desc(input logic [8:0] pos);
        in_desc = (pos >= POS_DESC_FIRST) && (pos <= POS_DESC_LAST);
    endfunction : in_desc

    // Function: next slot number with circular wrap
    function automatic logic [SLOT_W-1:0] slot_next(input logic [SLOT_W-1:0] s);
        slot_next = (s == SLOT_COUNT - SLOT_ONE) ? '0 : s + SLOT_ONE;
    endfunction : slot_next

    // Recording state
    logic [7:0]        start_lba_q;   // LBA low held from subcommand issue
    logic [7:0]        cap_status_q;  // Captured status
    logic [15:0]       cap_hours_q;   // Captured hours
    logic [7:0]        cap_chk_q;     // Captured checkpoint
    logic [47:0]       cap_lba_q;     // Captured failing address
    logic [7:0]        cap_low_q;     // LBA low for the entry being stored
    logic              wr_act_q;      // Store in progress
    logic [3:0]        wr_cnt_q;      // Byte being stored
    logic [SLOT_W-1:0] wr_slot_q;     // Slot receiving the next descriptor
    logic [SLOT_W:0]   filled_q;      // Slots holding results, saturating
    logic [15:0]       index_q;       // Newest descriptor index
    logic [7:0]        wr_byte;       // Byte headed for memory

    // Read state
    stlsb_rd_state_t   rd_state_q;    // Read sequencer
    logic              in_range_q;    // Requested sector is implemented
    logic              first_q;       // Requested sector is sector 0
    logic [8:0]        a_pos_q;       // Stage A byte position
    logic [4:0]        a_off_q;       // Stage A offset in descriptor
    logic [4:0]        a_ent_q;       // Stage A descriptor in sector
    logic [SLOT_W-1:0] a_slot_q;      // Stage A global slot
    logic              b_act_q;       // Stage B holds a byte
    logic [8:0]        b_pos_q;       // Stage B byte position
    logic              b_mem_q;       // Stage B takes memory data
    logic [7:0]        sum_q;         // Running sum of emitted bytes
    logic [7:0]        mem_rd;        // Memory read byte
    logic [7:0]        b_byte;        // Composed stage B byte
    logic [SLOT_W-1:0] base_slot;     // First slot of requested sector

    // Latch the LBA low value when the subcommand is issued
    always_ff @(posedge clk) begin
        if (rst) begin
            start_lba_q <= '0;
        end else if (test_start) begin
            start_lba_q <= test_lba_low;
        end
    end

    // Capture completion values; a completion during a store is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_status_q <= '0;
            cap_hours_q  <= '0;
            cap_chk_q    <= '0;
            cap_lba_q    <= '0;
            cap_low_q    <= '0;
        end else if (test_done && !wr_act_q) begin
            cap_low_q    <= start_lba_q;
            cap_status_q <= test_status;
            cap_hours_q  <= test_hours;
            cap_chk_q    <= test_checkpoint;
            // Short entries keep only their 28 address bits
            cap_lba_q    <= test_is_28bit ? (test_fail_lba & LBA28_MASK) : test_fail_lba;
        end
    end

    // Select the descriptor byte being stored
    always_comb begin
        case (wr_cnt_q)
            D_LBA_LOW:    wr_byte = cap_low_q;
            D_STATUS:     wr_byte = cap_status_q;
            D_HOURS_LO:   wr_byte = cap_hours_q[7:0];
            D_HOURS_HI:   wr_byte = cap_hours_q[15:8];
            D_CHECKPOINT: wr_byte = cap_chk_q;
            default: begin
                // Failing address bytes, least significant first
                wr_byte = cap_lba_q[8*(wr_cnt_q - D_FAIL_LBA0) +: 8];
            end
        endcase
    end

    // Store sequencer: eleven bytes per descriptor
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_act_q <= 1'b0;
            wr_cnt_q <= '0;
        end else if (!wr_act_q) begin
            wr_act_q <= test_done;
            wr_cnt_q <= '0;
        end else if (wr_cnt_q == WR_LAST_BYTE) begin
            wr_act_q <= 1'b0;
        end else begin
            wr_cnt_q <= wr_cnt_q + 4'h1;
        end
    end

    // Slot pointer, fill count and index advance when a store ends
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_slot_q <= '0;
            filled_q  <= '0;
            index_q   <= '0;
        end else if (wr_act_q && wr_cnt_q == WR_LAST_BYTE) begin
            wr_slot_q <= slot_next(wr_slot_q);
            index_q   <= {9'h000, wr_slot_q} + 16'h0001;
            if (filled_q != {1'b0, SLOT_COUNT}) begin
                filled_q <= filled_q + 8'h01;
            end
        end
    end

    // Descriptor memory
    stlsb_desc_mem #(
        .AW      (MEM_AW)
    ) u_mem (
        .clk     (clk),
        .wr_en   (wr_act_q),
        .wr_addr ({wr_slot_q, wr_cnt_q}),
        .wr_data (wr_byte),
        .rd_addr ({a_slot_q, a_off_q[3:0]}),
        .rd_data (mem_rd)
    );

    // First slot of the requested sector, only meaningful in range
    assign base_slot = SLOT_W'(rd_sector[SLOT_W-1:0] * ENT_PER_SECTOR);

    // Read sequencer and stage A position counters
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_state_q <= STLSB_IDLE;
            in_range_q <= 1'b0;
            first_q    <= 1'b0;
            a_pos_q    <= '0;
            a_off_q    <= '0;
            a_ent_q    <= '0;
            a_slot_q   <= '0;
        end else begin
            case (rd_state_q)
                STLSB_IDLE: begin
                    if (rd_req) begin
                        rd_state_q <= STLSB_STREAM;
                        in_range_q <= (rd_sector < LOG_SECTORS);
                        first_q    <= (rd_sector == 16'h0000);
                        a_pos_q    <= '0;
                        a_off_q    <= '0;
                        a_ent_q    <= '0;
                        a_slot_q   <= base_slot;
                    end
                end
                STLSB_STREAM: begin
                    a_pos_q <= a_pos_q + 9'h001;
                    if (in_desc(a_pos_q)) begin
                        // Step through 26-byte descriptors
                        if (a_off_q == DESC_LAST_OFF) begin
                            a_off_q  <= '0;
                            a_ent_q  <= a_ent_q + 5'h01;
                            if (a_ent_q != ENT_PER_SECTOR - 5'h01) begin
                                a_slot_q <= slot_next(a_slot_q);
                            end
                        end else begin
                            a_off_q <= a_off_q + 5'h01;
                        end
                    end
                    if (a_pos_q == POS_CHECKSUM) begin
                        rd_state_q <= STLSB_DRAIN;
                    end
                end
                STLSB_DRAIN: begin
                    rd_state_q <= STLSB_IDLE;
                end
                default: begin
                    rd_state_q <= STLSB_IDLE;
                end
            endcase
        end
    end

    // Stage B bookkeeping, aligned with the memory read latency
    always_ff @(posedge clk) begin
        if (rst) begin
            b_act_q <= 1'b0;
            b_pos_q <= '0;
            b_mem_q <= 1'b0;
        end else begin
            b_act_q <= (rd_state_q == STLSB_STREAM);
            b_pos_q <= a_pos_q;
            // Only written slots, used offsets and the eighteen entries come from memory;
            // the spare 26 bytes after entry eighteen would otherwise repeat its slot
            b_mem_q <= in_range_q && in_desc(a_pos_q) && (a_off_q < DESC_USED_BYTES)
                       && (a_ent_q < ENT_PER_SECTOR)
                       && ({1'b0, a_slot_q} < filled_q);
        end
    end

    // Compose the sector byte for the current position
    always_comb begin
        b_byte = 8'h00;
        if (b_pos_q == POS_CHECKSUM) begin
            b_byte = 8'h00 - sum_q;
        end else if (b_mem_q) begin
            b_byte = mem_rd;
        end else if (first_q && b_pos_q == POS_REVISION) begin
            b_byte = LOG_REVISION;
        end else if (first_q && b_pos_q == POS_INDEX_LO) begin
            b_byte = index_q[7:0];
        end else if (first_q && b_pos_q == POS_INDEX_HI) begin
            b_byte = index_q[15:8];
        end
    end

    // Running sum of bytes emitted in this sector
    always_ff @(posedge clk) begin
        if (rst) begin
            sum_q <= '0;
        end else if (!b_act_q) begin
            sum_q <= '0;
        end else begin
            sum_q <= sum_q + b_byte;
        end
    end

    // Registered sector output
    always_ff @(posedge clk) begin
        if (rst) begin
            log_valid <= 1'b0;
            log_data  <= '0;
            log_last  <= 1'b0;
        end else begin
            log_valid <= b_act_q;
            log_data  <= b_act_q ? b_byte : 8'h00;
            log_last  <= b_act_q && (b_pos_q == POS_CHECKSUM);
        end
    end

    // Registered status outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            rec_busy  <= 1'b0;
            rd_busy   <= 1'b0;
            log_index <= '0;
        end else begin
            rec_busy  <= wr_act_q || test_done;
            rd_busy   <= (rd_state_q != STLSB_IDLE) || rd_req;
            log_index <= index_q;
        end
    end
endmodule : stlsb_builder

/* rtl/stlsb_desc_mem.sv */
// Descriptor byte memory with one write port and a registered read port
`timescale 1ns/1ps
module stlsb_desc_mem #(
    parameter int unsigned AW = 11  // Address width
) (
    input  wire logic          clk,     // System clock
    input  wire logic          wr_en,   // Write strobe
    input  wire logic [AW-1:0] wr_addr, // Write address
    input  wire logic [7:0]    wr_data, // Write byte
    input  wire logic [AW-1:0] rd_addr, // Read address
    output logic      [7:0]    rd_data  // Registered read byte
);
    logic [7:0] mem [0:(1<<AW)-1];  // Byte storage, no reset needed

    // Write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : stlsb_desc_mem

/* verification/stlsb_builder_monitor.sv */
// Concurrent checks on the log sector builder ports
`timescale 1ns/1ps
module stlsb_builder_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        test_done,
    input wire logic        rd_req,
    input wire logic [15:0] rd_sector,
    input wire logic        rec_busy,
    input wire logic        rd_busy,
    input wire logic        log_valid,
    input wire logic [7:0]  log_data,
    input wire logic        log_last,
    input wire logic [15:0] log_index
);
    import stlsb_pkg::*;
    logic [8:0]  pos_q; // Byte position inside the stream
    logic [7:0]  sum_q; // Running sum of emitted bytes
    logic [15:0] sec_q; // Sector of the accepted request
    // Position and sum restart whenever the strobe is low
    always_ff @(posedge clk) begin
        if (rst || !log_valid) begin
            pos_q <= 9'h000;
            sum_q <= 8'h00;
        end else begin
            pos_q <= pos_q + 9'h001;
            sum_q <= sum_q + log_data;
        end
    end
    // Remember the sector of an accepted request
    always_ff @(posedge clk) begin
        if (rd_req && !rd_busy)
            sec_q <= rd_sector;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_answer;
        rd_req && !rd_busy |=> !log_valid ##1 !log_valid ##1 (log_valid && pos_q == 9'h000);
    endproperty
    a_answer: assert property (p_answer) else $error("first byte not at third cycle");
    property p_last;
        log_last |-> log_valid && pos_q == 9'h1ff;
    endproperty
    a_last: assert property (p_last) else $error("last marker off byte 511");
    property p_len;
        log_valid && pos_q == 9'h1ff |-> log_last ##1 !log_valid;
    endproperty
    a_len: assert property (p_len) else $error("stream not 512 bytes");
    property p_sum;
        log_last |-> (sum_q + log_data) == 8'h00;
    endproperty
    a_sum: assert property (p_sum) else $error("sector sum not zero");
    property p_rev;
        log_valid && pos_q == 9'h000 && sec_q == 16'h0000 |-> log_data == LOG_REVISION;
    endproperty
    a_rev: assert property (p_rev) else $error("revision byte wrong");
    property p_resv;
        log_valid && (pos_q == 9'h001 || (pos_q < 9'h004 && sec_q != 16'h0000)) |-> log_data == 8'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("header reserved byte not zero");
    property p_index;
        log_valid && pos_q == 9'h002 && sec_q == 16'h0000
            |-> log_data == log_index[7:0] ##1 log_data == log_index[15:8];
    endproperty
    a_index: assert property (p_index) else $error("index bytes wrong");
    property p_tail;
        log_valid && pos_q > POS_DESC_LAST && pos_q < POS_CHECKSUM |-> log_data == 8'h00;
    endproperty
    a_tail: assert property (p_tail) else $error("vendor or reserved tail not zero");
    // Bytes 472 to 497 lie past the eighteenth entry and hold no descriptor
    property p_spare;
        log_valid && pos_q >= 9'h1d8 && pos_q <= POS_DESC_LAST |-> log_data == 8'h00;
    endproperty
    a_spare: assert property (p_spare) else $error("spare descriptor area not zero");
    property p_busy;
        test_done && !rec_busy |=> rec_busy [*8] ##1 rec_busy [*4];
    endproperty
    a_busy: assert property (p_busy) else $error("store busy too short");
    property p_step;
        test_done && !rec_busy |-> ##13 log_index == (($past(log_index, 13) == {9'h000, SLOT_COUNT})
            ? 16'h0001 : $past(log_index, 13) + 16'h0001);
    endproperty
    a_step: assert property (p_step) else $error("index step or wrap wrong");
    c_read: cover property (rd_req && !rd_busy && rd_sector == 16'h0000);
    c_store: cover property (test_done && !rec_busy);
    c_wrap: cover property (log_index == 16'h0001 && $past(log_index) == {9'h000, SLOT_COUNT});
endmodule : stlsb_builder_monitor
bind stlsb_builder stlsb_builder_monitor stlsb_builder_monitor_inst (.clk(clk), .rst(rst),
    .test_done(test_done), .rd_req(rd_req), .rd_sector(rd_sector), .rec_busy(rec_busy),
    .rd_busy(rd_busy), .log_valid(log_valid), .log_data(log_data), .log_last(log_last),
    .log_index(log_index));

/* verification/stlsb_host_model.sv */
// Host model that requests one log sector and captures the stream
`timescale 1ns/1ps
module stlsb_host_model (
    input  wire logic        clk,
    input  wire logic        rd_busy,
    input  wire logic        log_valid,
    input  wire logic [7:0]  log_data,
    input  wire logic        log_last,
    output logic             rd_req,
    output logic [15:0]      rd_sector
);
    logic [7:0] sec_buf [512]; // Captured sector bytes
    logic [8:0] pos_q = 9'h000; // Capture position
    initial begin
        rd_req = 1'b0;
        rd_sector = 16'h0000;
    end
    // Store every strobed byte in arrival order
    always @(posedge clk) begin
        if (log_valid) begin
            sec_buf[pos_q] <= log_data;
            pos_q <= log_last ? 9'h000 : pos_q + 9'h001;
        end
    end
    // One request pulse, then wait for the stream to end
    task automatic read_sector(input logic [15:0] s, output logic ok);
        int n;
        @(posedge clk);
        rd_req <= 1'b1;
        rd_sector <= s;
        @(posedge clk);
        rd_req <= 1'b0;
        rd_sector <= ~s; // No stale sector once the request pulse drops
        ok = 1'b0;
        for (n = 0; n < 600 && !ok; n++) begin
            @(posedge clk);
            #1;
            ok = !rd_busy;
        end
    endtask : read_sector
endmodule : stlsb_host_model

/* verification/testbench.sv */
// Self-checking bench for the log sector builder
`timescale 1ns/1ps
module testbench;
    import stlsb_pkg::*;
    logic clk = 1'b0, rst = 1'b1, test_start = 1'b0, test_done = 1'b0, test_is_28bit = 1'b0;
    logic [7:0] test_lba_low = 8'h00, test_status = 8'h00, test_checkpoint = 8'h00;
    logic [15:0] test_hours = 16'h0000;
    logic [47:0] test_fail_lba = 48'h0;
    logic rd_req, rec_busy, rd_busy, log_valid, log_last;
    logic [15:0] rd_sector, log_index;
    logic [7:0] log_data;
    logic [7:0] slot_mem [72][11] = '{default: 8'h00}; // Expected stored descriptor bytes
    int next_slot = 0, cycles = 0, n_mismatch = 0, comparisons = 0;
    logic [15:0] exp_index = 16'h0000; // Expected newest index
    always #5 clk = ~clk;
    stlsb_builder stlsb_builder_inst (.clk(clk), .rst(rst), .test_start(test_start),
        .test_lba_low(test_lba_low), .test_done(test_done), .test_status(test_status),
        .test_hours(test_hours), .test_checkpoint(test_checkpoint), .test_fail_lba(test_fail_lba),
        .test_is_28bit(test_is_28bit), .rd_req(rd_req), .rd_sector(rd_sector), .rec_busy(rec_busy),
        .rd_busy(rd_busy), .log_valid(log_valid), .log_data(log_data), .log_last(log_last),
        .log_index(log_index));
    stlsb_host_model stlsb_host_model_inst (.clk(clk), .rd_busy(rd_busy), .log_valid(log_valid),
        .log_data(log_data), .log_last(log_last), .rd_req(rd_req), .rd_sector(rd_sector));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t index %h expected %h", $time, got, exp);
        end
    endtask : check16
    // Expected byte of a sector from the bench's own copy of the log
    function automatic logic [7:0] exp_byte(input int s, input int p);
        int e;
        int o;
        e = (p - 4) / 26;
        o = (p - 4) % 26;
        if (s >= int'(LOG_SECTORS)) return 8'h00;
        if (s == 0 && p == 0) return LOG_REVISION;
        if (s == 0 && p == 2) return exp_index[7:0];
        if (s == 0 && p == 3) return exp_index[15:8];
        if (p >= 4 && p <= 497 && o < 11 && e < int'(ENT_PER_SECTOR)) return slot_mem[s * 18 + e][o];
        return 8'h00;
    endfunction : exp_byte
    // One self-test; extra sends a second completion while the store runs
    task automatic record(input logic [7:0] k, input logic is28, input logic extra);
        logic [47:0] fl;
        int i;
        fl = {k, 8'h71, 8'h3c, ~k, 8'hd2, k};
        @(posedge clk);
        test_start <= 1'b1;
        test_lba_low <= k;
        @(posedge clk);
        {test_start, test_done, test_is_28bit} <= {1'b0, 1'b1, is28};
        test_lba_low <= ~k;
        test_status <= k ^ 8'h5a;
        test_hours <= {8'hc3, k};
        test_checkpoint <= ~k;
        test_fail_lba <= fl;
        @(posedge clk);
        test_done <= 1'b0;
        repeat (3) @(posedge clk);
        test_done <= extra;
        test_status <= 8'hee;
        @(posedge clk);
        test_done <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        if (is28) fl = fl & LBA28_MASK;
        slot_mem[next_slot][0] = k;
        slot_mem[next_slot][1] = k ^ 8'h5a;
        slot_mem[next_slot][2] = k;
        slot_mem[next_slot][3] = 8'hc3;
        slot_mem[next_slot][4] = ~k;
        for (i = 0; i < 6; i++) slot_mem[next_slot][5 + i] = fl[8 * i +: 8];
        next_slot = (next_slot + 1) % int'(SLOT_COUNT);
        exp_index = (next_slot == 0) ? {9'h000, SLOT_COUNT} : 16'(next_slot);
        check16(log_index, exp_index);
    endtask : record
    // Read one sector through the host and compare every byte
    task automatic check_sector(input logic [15:0] s);
        logic ok;
        logic [7:0] sum;
        logic [7:0] e;
        int p;
        stlsb_host_model_inst.read_sector(s, ok);
        check8({7'h00, ok}, 8'h01);
        sum = 8'h00;
        for (p = 0; p < 511; p++) begin
            e = exp_byte(int'(s), p);
            sum = sum + e;
            check8(stlsb_host_model_inst.sec_buf[p], e);
        end
        check8(stlsb_host_model_inst.sec_buf[511], 8'h00 - sum);
    endtask : check_sector
    task automatic t_empty;
        check16(log_index, 16'h0000);
        check_sector(16'h0000);
        $display("test empty done");
    endtask : t_empty
    task automatic t_entries;
        record(8'h81, 1'b0, 1'b0);
        record(8'hf2, 1'b1, 1'b1);
        check_sector(16'h0000);
        $display("test entries done");
    endtask : t_entries
    task automatic t_wrap;
        int k;
        for (k = 3; k <= 73; k++) record(8'(k), k[0], 1'b0);
        check16(log_index, 16'h0001);
        check_sector(16'h0000);
        check_sector(16'h0003);
        check_sector(16'h0004);
        check_sector(16'hffff);
        $display("test wrap done");
    endtask : t_wrap
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_empty;
        t_entries;
        t_wrap;
        summarize;
    end
endmodule : testbench
